// file: rtl/usb_ctrl_phy_stall_regs.sv
// Stall arming, NAK retry timing, stall/NAK flags, muxing, power and transceiver control
//
// Functional notes
// - Endpoint 0 stalls a direction only when arm bit and buffer stall bit are set.
// - A received SETUP clears both endpoint 0 arm bits.
// - As host, after a NAK wait the programmed microseconds before retrying.
// - Full speed delay is bits 25:16 of retry register, reset 0x010.
// - Low speed delay is bits 9:0 of retry register, reset 0x010.
// - Device mode: flag sets on NAK or STALL sent with its enable set.
// - Endpoint 0 enables come from engine control; others from endpoint control.
// - Connection select picks internal, external transceiver or pads, plus soft connect.
// - Power register gives override values and enables for bus sense and overcurrent.
// - Direct transceiver bits act only while their override enable is set.
// - Drive mode 0 single-ended, 1 differential ignoring minus data and enable.
// - Power-down overrides power down transmitter or receiver when set.
// - Differential: plus data drives plus pin, inverse on minus, gated by plus enable.
// - Single-ended: each data bit drives its own pin, gated by its enable.
// - Output enable 0 leaves pin undriven, 1 drives it.
// - Second pull-up select 0 gives second resistor only, 1 both.
// - Raw stall/NAK interrupt is high while any flag bit is set.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module usb_ctrl_phy_stall_regs
  import usb_ctrl_phy_stall_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic [7:0]     address,
  input  wire logic [31:0]    writeData,
  input  wire logic           writeStrobe,
  input  wire logic           readStrobe,
  output logic      [31:0]    readData,
  input  wire logic           deviceMode,
  input  wire logic           setupReceived,
  input  wire logic [1:0]     ep0BufferStall,
  output logic      [1:0]     ep0StallSend,
  input  wire logic           engineIrqOnNak,
  input  wire logic           engineIrqOnStall,
  input  wire logic [15:1]    endpointIrqOnNak,
  input  wire logic [15:1]    endpointIrqOnStall,
  input  wire logic [31:0]    nakSent,
  input  wire logic [31:0]    stallSent,
  output logic                stallNakIrqRaw,
  input  wire logic           nakReceived,
  input  wire logic           lowSpeedTarget,
  output logic                retryWaiting,
  output logic                retryNow,
  output logic                connectInternalTransceiver,
  output logic                connectExternalTransceiver,
  output logic                connectDigitalPads,
  output logic                softConnect,
  input  wire logic           busVoltageSensePin,
  input  wire logic           overcurrentSensePin,
  input  wire logic           busPowerEnableCtrl,
  output logic                busVoltageSense,
  output logic                overcurrentSense,
  output logic                busPowerEnable,
  input  wire phy_ctrl_type   phyCtrlNormal,
  input  wire phy_status_type phyStatusPins,
  output phy_ctrl_type        phyCtrl,
  output logic                plusPinOut,
  output logic                plusPinOe,
  output logic                minusPinOut,
  output logic                minusPinOe,
  output logic                plusPullupFirst,
  output logic                plusPullupSecond,
  output logic                minusPullupFirst,
  output logic                minusPullupSecond
);

  // ==========================================
  // Register state
  logic [1:0]           stallArm_reg;
  logic [9:0]           fsDelay_reg;
  logic [9:0]           lsDelay_reg;
  logic [31:0]          flags_reg;
  logic [3:0]           conn_reg;
  logic [5:0]           power_reg;
  logic [31:0]          phyDirect_reg;
  logic [31:0]          phyOverride_reg;
  logic [31:0]          readData_next;
  logic [8:0]           syncFirst_reg;
  logic [8:0]           syncSecond_reg;
  phy_status_type       phyStatus;
  logic                 wrArm;
  logic                 wrRetry;
  logic                 wrFlags;
  logic                 wrConn;
  logic                 wrPower;
  logic                 wrPhy;
  logic                 wrOvr;

  assign wrArm   = writeStrobe && (address == OFS_STALL_ARM);
  assign wrRetry = writeStrobe && (address == OFS_RETRY);
  assign wrFlags = writeStrobe && (address == OFS_FLAGS);
  assign wrConn  = writeStrobe && (address == OFS_CONN);
  assign wrPower = writeStrobe && (address == OFS_POWER);
  assign wrPhy   = writeStrobe && (address == OFS_PHY);
  assign wrOvr   = writeStrobe && (address == OFS_PHY_OVR);

  // ==========================================
  // Pin synchronisers
  // Only the second stage is read anywhere
  always_ff @(posedge clk) begin
    if (rst) begin
      syncFirst_reg  <= 9'h000;
      syncSecond_reg <= 9'h000;
    end else begin
      syncFirst_reg  <= {overcurrentSensePin, busVoltageSensePin, phyStatusPins};
      syncSecond_reg <= syncFirst_reg;
    end
  end

  assign phyStatus = phy_status_type'(syncSecond_reg[6:0]);

  // ==========================================
  // Endpoint 0 stall arming
  always_ff @(posedge clk) begin
    if (rst) begin
      stallArm_reg <= 2'h0;
    end else if (setupReceived) begin
      // SETUP must end any stall, so it beats a same-cycle write
      stallArm_reg <= 2'h0;
    end else if (wrArm) begin
      stallArm_reg <= writeData[1:0];
    end
  end

  assign ep0StallSend = stallArm_reg & ep0BufferStall;

  // ==========================================
  // NAK retry delay
  retry_state_type retryState_reg;
  logic [6:0]      usTick_reg;
  logic [9:0]      usLeft_reg;
  logic [9:0]      delaySel;

  always_ff @(posedge clk) begin
    if (rst) begin
      fsDelay_reg <= DELAY_RST;
      lsDelay_reg <= DELAY_RST;
    end else if (wrRetry) begin
      fsDelay_reg <= writeData[FS_DELAY_LSB +: DELAY_W];
      lsDelay_reg <= writeData[LS_DELAY_LSB +: DELAY_W];
    end
  end

  assign delaySel = lowSpeedTarget ? lsDelay_reg : fsDelay_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      retryState_reg <= RETRY_IDLE;
      usTick_reg     <= 7'h00;
      usLeft_reg     <= 10'h000;
    end else begin
      case (retryState_reg)
        RETRY_IDLE: begin
          if (nakReceived && !deviceMode) begin
            usTick_reg <= 7'h00;
            usLeft_reg <= delaySel;
            // A zero delay retries at once
            retryState_reg <= (delaySel == 10'h000) ? RETRY_GO : RETRY_WAIT;
          end
        end
        RETRY_WAIT: begin
          if (usTick_reg == US_LAST) begin
            usTick_reg <= 7'h00;
            usLeft_reg <= usLeft_reg - 10'h001;
            if (usLeft_reg == 10'h001) begin
              retryState_reg <= RETRY_GO;
            end
          end else begin
            usTick_reg <= usTick_reg + 7'h01;
          end
        end
        RETRY_GO: begin
          retryState_reg <= RETRY_IDLE;
        end
        default: begin
          retryState_reg <= RETRY_IDLE;
        end
      endcase
    end
  end

  assign retryWaiting = (retryState_reg == RETRY_WAIT);
  assign retryNow     = (retryState_reg == RETRY_GO);

  // ==========================================
  // Stall/NAK flags
  logic [15:0] irqOnNak;
  logic [15:0] irqOnStall;
  logic [31:0] nakEnable;
  logic [31:0] stallEnable;
  logic [31:0] flagEvents;
  logic [31:0] flagClear;

  assign irqOnNak   = {endpointIrqOnNak, engineIrqOnNak};
  assign irqOnStall = {endpointIrqOnStall, engineIrqOnStall};

  genvar ep;
  generate
    for (ep = 0; ep < 16; ep++) begin : gEp
      // IN at even bit, OUT at odd bit
      assign nakEnable[2*ep +: 2]   = {2{irqOnNak[ep]}};
      assign stallEnable[2*ep +: 2] = {2{irqOnStall[ep]}};
    end
  endgenerate

  assign flagEvents = deviceMode ? ((nakSent & nakEnable) | (stallSent & stallEnable)) : 32'h0000_0000;
  assign flagClear  = wrFlags ? writeData : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= 32'h0000_0000;
    end else begin
      // New events win over a same-cycle clear
      flags_reg <= (flags_reg & ~flagClear) | flagEvents;
    end
  end

  assign stallNakIrqRaw = |flags_reg;

  // ==========================================
  // Connection select and power overrides
  always_ff @(posedge clk) begin
    if (rst) begin
      conn_reg  <= 4'h0;
      power_reg <= 6'h00;
    end else begin
      if (wrConn) begin
        conn_reg <= writeData[3:0];
      end
      if (wrPower) begin
        power_reg <= writeData[5:0];
      end
    end
  end

  assign connectInternalTransceiver = conn_reg[0];
  assign connectExternalTransceiver = conn_reg[1];
  assign connectDigitalPads         = conn_reg[2];
  assign softConnect                = conn_reg[3];

  // Value and enable live in one register; software orders the writes
  assign busVoltageSense  = power_reg[PWR_VDET_EN] ? power_reg[PWR_VDET] : syncSecond_reg[7];
  assign overcurrentSense = power_reg[PWR_OVC_EN] ? power_reg[PWR_OVC] : syncSecond_reg[8];
  assign busPowerEnable   = power_reg[PWR_VEN_EN] ? power_reg[PWR_VEN] : busPowerEnableCtrl;

  // ==========================================
  // Direct transceiver control
  phy_ctrl_type direct;
  phy_ctrl_type chosen;

  always_ff @(posedge clk) begin
    if (rst) begin
      phyDirect_reg   <= 32'h0000_0000;
      phyOverride_reg <= 32'h0000_0000;
    end else begin
      if (wrPhy) begin
        phyDirect_reg <= writeData & PHY_MASK;
      end
      if (wrOvr) begin
        phyOverride_reg <= writeData & OVR_MASK;
      end
    end
  end

  assign direct.diffMode          = phyDirect_reg[PHY_DIFF];
  assign direct.fsSlew            = phyDirect_reg[PHY_SLEW];
  assign direct.txPowerDown       = phyDirect_reg[PHY_TXPD];
  assign direct.rxPowerDown       = phyDirect_reg[PHY_RXPD];
  assign direct.minusData         = phyDirect_reg[PHY_MDATA];
  assign direct.plusData          = phyDirect_reg[PHY_PDATA];
  assign direct.minusOe           = phyDirect_reg[PHY_MOE];
  assign direct.plusOe            = phyDirect_reg[PHY_POE];
  assign direct.minusPulldown     = phyDirect_reg[PHY_MPDN];
  assign direct.minusPullup       = phyDirect_reg[PHY_MPUP];
  assign direct.minusSecondPullup = phyDirect_reg[PHY_MHI];
  assign direct.plusPulldown      = phyDirect_reg[PHY_PPDN];
  assign direct.plusPullup        = phyDirect_reg[PHY_PPUP];
  assign direct.plusSecondPullup  = phyDirect_reg[PHY_PHI];

  // Each field falls back to the controller unless its enable is set
  always_comb begin
    chosen = phyCtrlNormal;
    if (phyOverride_reg[OVR_DIFF]) chosen.diffMode = direct.diffMode;
    if (phyOverride_reg[OVR_SLEW]) chosen.fsSlew = direct.fsSlew;
    if (phyOverride_reg[OVR_TXPD]) chosen.txPowerDown = direct.txPowerDown;
    if (phyOverride_reg[OVR_RXPD]) chosen.rxPowerDown = direct.rxPowerDown;
    if (phyOverride_reg[OVR_MDATA]) chosen.minusData = direct.minusData;
    if (phyOverride_reg[OVR_PDATA]) chosen.plusData = direct.plusData;
    if (phyOverride_reg[OVR_MOE]) chosen.minusOe = direct.minusOe;
    if (phyOverride_reg[OVR_POE]) chosen.plusOe = direct.plusOe;
    if (phyOverride_reg[OVR_MPDN]) chosen.minusPulldown = direct.minusPulldown;
    if (phyOverride_reg[OVR_MPUP]) chosen.minusPullup = direct.minusPullup;
    if (phyOverride_reg[OVR_MHI]) chosen.minusSecondPullup = direct.minusSecondPullup;
    if (phyOverride_reg[OVR_PPDN]) chosen.plusPulldown = direct.plusPulldown;
    if (phyOverride_reg[OVR_PPUP]) chosen.plusPullup = direct.plusPullup;
    if (phyOverride_reg[OVR_PHI]) chosen.plusSecondPullup = direct.plusSecondPullup;
  end

  // Pin drive registered so the pads see glitch-free levels
  always_ff @(posedge clk) begin
    if (rst) begin
      phyCtrl           <= '0;
      plusPinOut        <= 1'b0;
      plusPinOe         <= 1'b0;
      minusPinOut       <= 1'b0;
      minusPinOe        <= 1'b0;
      plusPullupFirst   <= 1'b0;
      plusPullupSecond  <= 1'b0;
      minusPullupFirst  <= 1'b0;
      minusPullupSecond <= 1'b0;
    end else begin
      phyCtrl    <= chosen;
      plusPinOut <= chosen.plusData;
      // A powered-down transmitter never drives
      plusPinOe <= chosen.plusOe && !chosen.txPowerDown;
      if (chosen.diffMode) begin
        minusPinOut <= ~chosen.plusData;
        minusPinOe  <= chosen.plusOe && !chosen.txPowerDown;
      end else begin
        minusPinOut <= chosen.minusData;
        minusPinOe  <= chosen.minusOe && !chosen.txPowerDown;
      end
      plusPullupSecond  <= chosen.plusPullup;
      plusPullupFirst   <= chosen.plusPullup && chosen.plusSecondPullup;
      minusPullupSecond <= chosen.minusPullup;
      minusPullupFirst  <= chosen.minusPullup && chosen.minusSecondPullup;
    end
  end

  // ==========================================
  // Read path
  always_comb begin
    readData_next = 32'h0000_0000;
    case (address)
      OFS_STALL_ARM: readData_next = {30'h0, stallArm_reg};
      OFS_RETRY:     readData_next = {6'h00, fsDelay_reg, 6'h00, lsDelay_reg};
      OFS_FLAGS:     readData_next = flags_reg;
      OFS_CONN:      readData_next = {28'h0, conn_reg};
      OFS_POWER:     readData_next = {26'h0, power_reg};
      OFS_PHY:       readData_next = {9'h000, phyStatus, phyDirect_reg[15:0]};
      OFS_PHY_OVR:   readData_next = phyOverride_reg;
      default:       readData_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readData <= 32'h0000_0000;
    end else if (readStrobe) begin
      readData <= readData_next;
    end else begin
      readData <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// file: rtl/usb_ctrl_phy_stall_pkg.sv
// Shared constants and types for the stall, retry and transceiver register block
package usb_ctrl_phy_stall_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] OFS_STALL_ARM = 8'h68;
  localparam logic [7:0] OFS_RETRY     = 8'h6C;
  localparam logic [7:0] OFS_FLAGS     = 8'h70;
  localparam logic [7:0] OFS_CONN      = 8'h74;
  localparam logic [7:0] OFS_POWER     = 8'h78;
  localparam logic [7:0] OFS_PHY       = 8'h7C;
  localparam logic [7:0] OFS_PHY_OVR   = 8'h80;
  // ==========================================
  // Field positions
  localparam int FS_DELAY_LSB = 16;
  localparam int LS_DELAY_LSB = 0;
  localparam int DELAY_W      = 10;
  localparam int PWR_OVC_EN   = 5;
  localparam int PWR_OVC      = 4;
  localparam int PWR_VDET_EN  = 3;
  localparam int PWR_VDET     = 2;
  localparam int PWR_VEN_EN   = 1;
  localparam int PWR_VEN      = 0;
  localparam int PHY_STAT_LSB = 16;
  localparam int PHY_DIFF     = 15;
  localparam int PHY_SLEW     = 14;
  localparam int PHY_TXPD     = 13;
  localparam int PHY_RXPD     = 12;
  localparam int PHY_MDATA    = 11;
  localparam int PHY_PDATA    = 10;
  localparam int PHY_MOE      = 9;
  localparam int PHY_POE      = 8;
  localparam int PHY_MPDN     = 6;
  localparam int PHY_MPUP     = 5;
  localparam int PHY_MHI      = 4;
  localparam int PHY_PPDN     = 2;
  localparam int PHY_PPUP     = 1;
  localparam int PHY_PHI      = 0;
  localparam int OVR_DIFF     = 15;
  localparam int OVR_MPUP     = 12;
  localparam int OVR_SLEW     = 11;
  localparam int OVR_TXPD     = 10;
  localparam int OVR_RXPD     = 9;
  localparam int OVR_MDATA    = 8;
  localparam int OVR_PDATA    = 7;
  localparam int OVR_MOE      = 6;
  localparam int OVR_POE      = 5;
  localparam int OVR_MPDN     = 4;
  localparam int OVR_PPDN     = 3;
  localparam int OVR_PPUP     = 2;
  localparam int OVR_MHI      = 1;
  localparam int OVR_PHI      = 0;
  // ==========================================
  // Reset values and masks
  localparam logic [9:0]  DELAY_RST  = 10'h010;
  localparam logic [31:0] ARM_MASK   = 32'h0000_0003;
  localparam logic [31:0] CONN_MASK  = 32'h0000_000F;
  localparam logic [31:0] PWR_MASK   = 32'h0000_003F;
  localparam logic [31:0] PHY_MASK   = 32'h0000_FF77;
  localparam logic [31:0] OVR_MASK   = 32'h0000_9FFF;
  // ==========================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MICROSEC_NS   = 1000;
  localparam int US_CYCLES     = MICROSEC_NS / CLK_PERIOD_NS;
  localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);
  // ==========================================
  // Types
  typedef enum logic [1:0] {
    RETRY_IDLE = 2'b00,
    RETRY_WAIT = 2'b01,
    RETRY_GO   = 2'b11
  } retry_state_type;

  typedef struct packed {
    logic diffMode;
    logic fsSlew;
    logic txPowerDown;
    logic rxPowerDown;
    logic minusData;
    logic plusData;
    logic minusOe;
    logic plusOe;
    logic minusPulldown;
    logic minusPullup;
    logic minusSecondPullup;
    logic plusPulldown;
    logic plusPullup;
    logic plusSecondPullup;
  } phy_ctrl_type;

  typedef struct packed {
    logic minusOverVoltage;
    logic plusOverVoltage;
    logic minusOverCurrent;
    logic plusOverCurrent;
    logic minusRx;
    logic plusRx;
    logic diffRx;
  } phy_status_type;
endpackage

// file: verification/usb_ctrl_phy_stall_asserts.sv
// Concurrent checks on the ports of the stall, retry, power and transceiver block
`timescale 1ns/1ps
`default_nettype none
module usb_ctrl_phy_stall_asserts
  import usb_ctrl_phy_stall_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic [7:0]   address,
  input wire logic [31:0]  writeData,
  input wire logic         writeStrobe,
  input wire logic         deviceMode,
  input wire logic         setupReceived,
  input wire logic [1:0]   ep0BufferStall,
  input wire logic [1:0]   ep0StallSend,
  input wire logic         stallNakIrqRaw,
  input wire logic         nakReceived,
  input wire logic         lowSpeedTarget,
  input wire logic         retryWaiting,
  input wire logic         retryNow,
  input wire logic         busPowerEnableCtrl,
  input wire logic         busPowerEnable,
  input wire phy_ctrl_type phyCtrl,
  input wire logic         plusPinOut,
  input wire logic         plusPinOe,
  input wire logic         minusPinOut,
  input wire logic         minusPinOe,
  input wire logic         plusPullupFirst,
  input wire logic         plusPullupSecond
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Shadow registers
  logic [31:0] retryReg;
  logic [1:0]  powerReg;
  logic [16:0] waitCnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      retryReg <= 32'h0010_0010;
      powerReg <= 2'h0;
    end else if (writeStrobe && address == OFS_RETRY) begin
      retryReg <= writeData & 32'h03FF_03FF;
    end else if (writeStrobe && address == OFS_POWER) begin
      powerReg <= writeData[1:0];
    end
  end
  // Mirror of the retry wait, so its length is checked to the cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      waitCnt <= 17'h0;
    end else if (waitCnt != 17'h0) begin
      waitCnt <= waitCnt - 17'h1;
    end else if (nakReceived && !deviceMode) begin
      waitCnt <= 17'(US_CYCLES * (lowSpeedTarget ? retryReg[9:0] : retryReg[25:16]) + 1);
    end
  end
  sequence nakTaken;
    nakReceived && !deviceMode && waitCnt == 17'h0;
  endsequence
  // ==========================================
  // Properties
  stall_gate_a: assert property ((ep0StallSend & ~ep0BufferStall) == 2'h0)
    else $error("stall sent without buffer stall");
  setup_clear_a: assert property (setupReceived |=> ep0StallSend == 2'h0)
    else $error("stall still armed after setup");
  retry_start_a: assert property (nakTaken |=> retryWaiting || retryNow)
    else $error("nak not taken");
  retry_time_a: assert property (retryNow == (waitCnt == 17'h1))
    else $error("retry pulse at wrong cycle");
  retry_wait_a: assert property (retryWaiting == (waitCnt > 17'h1))
    else $error("retry wait level wrong");
  flag_hold_a: assert property (stallNakIrqRaw && !(writeStrobe && address == OFS_FLAGS) |=> stallNakIrqRaw)
    else $error("flag dropped without clear");
  power_ovr_a: assert property (busPowerEnable == (powerReg[1] ? powerReg[0] : busPowerEnableCtrl))
    else $error("bus power override wrong");
  diff_drive_a: assert property (phyCtrl.diffMode && !phyCtrl.txPowerDown |->
    minusPinOe == phyCtrl.plusOe && (!plusPinOe || (plusPinOut == phyCtrl.plusData && minusPinOut != plusPinOut)))
    else $error("differential drive wrong");
  single_drive_a: assert property (!phyCtrl.diffMode && !phyCtrl.txPowerDown |->
    plusPinOe == phyCtrl.plusOe && minusPinOe == phyCtrl.minusOe && (!plusPinOe || plusPinOut == phyCtrl.plusData)
    && (!minusPinOe || minusPinOut == phyCtrl.minusData))
    else $error("single ended drive wrong");
  tx_off_a: assert property (phyCtrl.txPowerDown |-> !plusPinOe && !minusPinOe)
    else $error("pins driven while powered down");
  pullup_sel_a: assert property (plusPullupSecond == phyCtrl.plusPullup
    && plusPullupFirst == (phyCtrl.plusPullup && phyCtrl.plusSecondPullup))
    else $error("pull-up selection wrong");
endmodule
bind usb_ctrl_phy_stall_regs usb_ctrl_phy_stall_asserts usb_ctrl_phy_stall_asserts_inst (.*);
`default_nettype wire

// file: verification/usb_phy_pin_model.sv
// Behavioural pad model of the transceiver lines feeding the status inputs
`timescale 1ns/1ps
`default_nettype none
module usb_phy_pin_model
  import usb_ctrl_phy_stall_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      plusPinOut,
  input  wire logic      plusPinOe,
  input  wire logic      minusPinOut,
  input  wire logic      minusPinOe,
  input  wire logic      plusPull,
  input  wire logic      minusPull,
  output phy_status_type statusPins
);
  // ==========================================
  // Line levels
  // A floating line with no pull-up keeps changing, never holding a stale value
  logic wobble;
  logic plusLevel;
  logic minusLevel;
  initial wobble = 1'b0;
  always @(posedge clk) wobble <= ~wobble;
  assign plusLevel  = plusPinOe ? plusPinOut : (plusPull | wobble);
  assign minusLevel = minusPinOe ? minusPinOut : (minusPull | ~wobble);
  assign statusPins = {4'h0, minusLevel, plusLevel, plusLevel & ~minusLevel};
endmodule
`default_nettype wire

// file: verification/usb_ctrl_phy_stall_regs_tb_top.sv
// Self-checking bench for the stall, retry, power and transceiver register block
`timescale 1ns/1ps
`default_nettype none
module usb_ctrl_phy_stall_regs_tb_top;
  import usb_ctrl_phy_stall_pkg::*;
  // ==========================================
  // Signals
  logic           clk, rst, writeStrobe, readStrobe, deviceMode, setupReceived, nakReceived;
  logic           engineIrqOnNak, engineIrqOnStall, lowSpeedTarget, busPowerEnableCtrl, retryNow;
  logic           busVoltageSensePin, overcurrentSensePin, stallNakIrqRaw, retryWaiting, softConnect;
  logic           connectInternalTransceiver, connectExternalTransceiver, connectDigitalPads;
  logic           busVoltageSense, overcurrentSense, busPowerEnable, plusPinOut, plusPinOe, minusPinOut;
  logic           minusPinOe, plusPullupFirst, plusPullupSecond, minusPullupFirst, minusPullupSecond;
  logic [1:0]     ep0BufferStall, ep0StallSend;
  logic [7:0]     address;
  logic [15:1]    endpointIrqOnNak, endpointIrqOnStall;
  logic [31:0]    writeData, readData, nakSent, stallSent;
  phy_ctrl_type   phyCtrlNormal, phyCtrl;
  phy_status_type phyStatusPins;
  int             num_errors, checks;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  usb_ctrl_phy_stall_regs usb_ctrl_phy_stall_regs_inst (.*);
  usb_phy_pin_model usb_phy_pin_model_inst (.clk, .plusPinOut, .plusPinOe, .minusPinOut, .minusPinOe,
    .plusPull(plusPullupSecond), .minusPull(minusPullupSecond), .statusPins(phyStatusPins));

  // ==========================================
  // Tasks
  task automatic close_out;
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address     <= a;
    writeData   <= d;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    address    <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    #1 chk(readData, exp);
  endtask
  // Counts cycles from the taking edge to the retry pulse
  task automatic nak(input logic ls, input int exp);
    int n;
    @(posedge clk);
    nakReceived    <= 1'b1;
    lowSpeedTarget <= ls;
    @(posedge clk);
    nakReceived <= 1'b0;
    n = 1;
    #1;
    while (retryNow !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n, exp);
    if (n >= 3000) close_out();
  endtask
  task automatic ev(input logic [31:0] n, input logic [31:0] s);
    @(posedge clk);
    nakSent   <= n;
    stallSent <= s;
    @(posedge clk);
    nakSent   <= 32'h0;
    stallSent <= 32'h0;
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    close_out();
  end

  // ==========================================
  // Sequence
  initial begin
    {rst, writeStrobe, readStrobe, deviceMode, setupReceived, nakReceived, engineIrqOnNak} = 7'h40;
    {engineIrqOnStall, lowSpeedTarget, busPowerEnableCtrl, busVoltageSensePin, overcurrentSensePin} = 5'h0;
    {ep0BufferStall, address, endpointIrqOnNak, endpointIrqOnStall} = '0;
    {writeData, nakSent, stallSent} = '0;
    phyCtrlNormal = 14'h0140;
    num_errors = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_RETRY, 32'h0010_0010);
    rd(OFS_FLAGS, 32'h0);
    rd(8'h40, 32'h0);
    chk({plusPinOut, plusPinOe, minusPinOut, minusPinOe}, 4'hC);
    @(posedge clk);
    ep0BufferStall <= 2'h1;
    wr(OFS_STALL_ARM, 32'hFFFF_FFFF);
    rd(OFS_STALL_ARM, 32'h3);
    chk(ep0StallSend, 2'h1);
    @(posedge clk);
    setupReceived <= 1'b1;
    @(posedge clk);
    setupReceived <= 1'b0;
    #1 chk(ep0StallSend, 2'h0);
    rd(OFS_STALL_ARM, 32'h0);
    wr(OFS_RETRY, 32'hFFFF_FFFF);
    rd(OFS_RETRY, 32'h03FF_03FF);
    wr(OFS_RETRY, 32'h0002_0001);
    nak(1'b1, 101);
    nak(1'b0, 201);
    wr(OFS_RETRY, 32'h0000_0001);
    nak(1'b0, 1);
    @(posedge clk);
    deviceMode         <= 1'b1;
    engineIrqOnNak     <= 1'b1;
    endpointIrqOnNak   <= 15'h4000;
    endpointIrqOnStall <= 15'h0001;
    ev(32'h4000_0015, 32'h0000_000A);
    rd(OFS_FLAGS, 32'h4000_0009);
    chk(stallNakIrqRaw, 1'b1);
    wr(OFS_FLAGS, 32'h4000_0001);
    rd(OFS_FLAGS, 32'h0000_0008);
    chk(stallNakIrqRaw, 1'b1);
    wr(OFS_FLAGS, 32'h0000_0008);
    rd(OFS_FLAGS, 32'h0);
    chk(stallNakIrqRaw, 1'b0);
    @(posedge clk);
    deviceMode <= 1'b0;
    ev(32'h4000_0015, 32'h0);
    rd(OFS_FLAGS, 32'h0);
    wr(OFS_CONN, 32'hFFFF_FFF5);
    rd(OFS_CONN, 32'h5);
    chk({softConnect, connectDigitalPads, connectExternalTransceiver, connectInternalTransceiver}, 4'h5);
    @(posedge clk);
    busPowerEnableCtrl <= 1'b1;
    wr(OFS_POWER, 32'h14);
    #1 chk({busVoltageSense, overcurrentSense, busPowerEnable}, 3'h1);
    wr(OFS_POWER, 32'h3E);
    #1 chk({busVoltageSense, overcurrentSense, busPowerEnable}, 3'h6);
    rd(OFS_POWER, 32'h3E);
    wr(OFS_PHY, 32'h0000_8533);
    settle();
    chk({plusPinOut, plusPinOe, minusPinOut, minusPinOe}, 4'hC);
    wr(OFS_PHY_OVR, 32'hFFFF_FFFF);
    rd(OFS_PHY_OVR, 32'h9FFF);
    settle();
    chk({plusPinOut, plusPinOe, minusPinOut, minusPinOe}, 4'hD);
    chk({plusPullupFirst, plusPullupSecond, minusPullupFirst, minusPullupSecond}, 4'hF);
    chk(phyCtrl.fsSlew, 1'b0);
    wr(OFS_PHY, 32'h0000_4A22);
    settle();
    chk({plusPinOut, plusPinOe, minusPinOut, minusPinOe}, 4'h3);
    chk({plusPullupFirst, plusPullupSecond, minusPullupFirst, minusPullupSecond}, 4'h5);
    chk(phyCtrl.fsSlew, 1'b1);
    wr(OFS_PHY, 32'h0000_7A22);
    settle();
    chk({phyCtrl.txPowerDown, phyCtrl.rxPowerDown, minusPinOe}, 3'h6);
    rd(OFS_PHY, 32'h0006_7A22);
    wr(OFS_PHY_OVR, 32'h0);
    settle();
    chk(phyCtrl, phyCtrlNormal);
    close_out();
  end
endmodule
`default_nettype wire
